// *** core/decim_pkg.sv ***
// Purpose: shared constants and types for the decimating low pass leg pipeline
// Assumes: one 20 MHz clock, synchronous active-high reset
// Notes: widths follow the fractional bit weightings of the gain chain
// Behaviour
// R1 - output is input times every stage gain
// R2 - shifter applies only power-of-two gains
// R3 - software sets exponent near minimum total gain
// R4 - in-phase and quadrature legs are identical
// R5 - integrate-dump, third-order comb, or bypass, optional compensation
// R6 - pipeline registers load every clock except decimated side
// R7 - gain loop accumulator updates once per output
// R8 - each integrator one clock delay, enabled per input
// R9 - interpolated mode enables integrators every clock
// R10 - gated mode enables integrators only on gated samples
// R11 - each asserted input enable admits one sample
// R12 - comb output rounded and saturated to 11 bits
// R13 - compensation output rounded and limited to 10 bits
// R14 - adaptive gain spans unity to 1.9375 times 128
// R15 - output enable is divider terminal-count pulse
// R16 - synchronous reset clears integrators, combs, gain accumulator
package decim_pkg;
    localparam int IN_W = 10;
    localparam int MIX_W = 12;
    localparam int ACC_W = 48;
    localparam int CIC_W = 11;
    localparam int OUT_W = 10;
    localparam int SHIFT_W = 6;
    localparam int DIV_W = 12;
    localparam int GAIN_W = 8;
    localparam int GAIN_FRAC = 4;
    localparam int GAIN_EXP_W = 3;
    localparam int SCALER_SHIFT = 36;
    localparam int CIC_FRAC_SHIFT = 38;
    localparam int COMP_FRAC = 6;
    localparam int MIX_ROUND = 9;
    localparam int ORDER = 3;
    // clocks from the divider pulse until the leg output carries the new sample
    localparam int VALID_LAG = 3;
    // bit 4 of the gain code is unused, so the ceiling is 1.9375 times 128
    localparam logic [GAIN_W-1:0] GAIN_MAX = 8'hEF;
    localparam logic [GAIN_W-1:0] GAIN_MIN = 8'h00;
    localparam logic [DIV_W-1:0] DIV_ONE = 12'h000;

    typedef enum logic [1:0] {
        FILT_DUMP = 2'b00,
        FILT_CIC3 = 2'b01,
        FILT_BYPASS = 2'b10
    } filt_mode_t;

    typedef enum logic [1:0] {
        COMP_NONE = 2'b00,
        COMP_SINC1 = 2'b01,
        COMP_SINC3 = 2'b10
    } comp_mode_t;

    typedef struct packed {
        filt_mode_t filt;
        comp_mode_t comp;
        logic gated;
        logic [SHIFT_W-1:0] shift_exp;
        logic [DIV_W-1:0] divisor_m1;
        logic [GAIN_W-1:0] loop_gain_step;
        logic [OUT_W-1:0] level_target;
    } filt_cfg_t;

    typedef struct packed {
        logic valid;
        logic signed [OUT_W-1:0] i;
        logic signed [OUT_W-1:0] q;
    } iq_sample_t;
endpackage

// *** core/decim_leg.sv ***
// Purpose: one filter leg: mixer round, scaler, gain, shifter, comb, compensation
// Assumes: enables come from the top level
// Notes: both legs use this module so latency matches exactly
`timescale 1ns/1ps
`default_nettype none
module decim_leg (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic samp_en_i,
    input wire logic out_en_i,
    input wire decim_pkg::filt_mode_t filt_i,
    input wire decim_pkg::comp_mode_t comp_i,
    input wire logic [decim_pkg::SHIFT_W-1:0] shift_exp_i,
    input wire logic [decim_pkg::GAIN_W-1:0] gain_i,
    input wire logic signed [decim_pkg::MIX_W+decim_pkg::IN_W-1:0] prod_i,
    output logic signed [decim_pkg::OUT_W-1:0] out_o
);
    import decim_pkg::*;

    logic signed [MIX_W-1:0] mix_q, mix_d;
    logic signed [ACC_W-1:0] gain_q, gain_d;
    logic signed [ACC_W-1:0] integ_q [ORDER];
    logic signed [ACC_W-1:0] integ_d [ORDER];
    logic signed [ACC_W-1:0] dump_q [ORDER];
    logic signed [ACC_W-1:0] dump_d [ORDER];
    logic signed [ACC_W-1:0] comb_v [ORDER+1];
    logic signed [ACC_W-1:0] comb_q, comb_d;
    logic signed [CIC_W-1:0] sat_q, sat_d, prev_q, prev_d;
    logic tap_en_q, tap_en_d;
    logic signed [OUT_W-1:0] out_q, out_d;
    logic signed [ACC_W-1:0] mant, shifted, pick, rnd;
    logic signed [CIC_W+COMP_FRAC+2:0] comp_acc, comp_rnd;

    ////////////////////////////////////////////////////////////////
    always_comb begin
        mix_d = MIX_W'((prod_i + (1 <<< (MIX_ROUND - 1))) >>> MIX_ROUND);
        // mantissa 1.xxxx times 2^exp covers 1.0 to 1.9375*128 [R14]
        mant = ACC_W'(mix_q) * ACC_W'({1'b0, 1'b1, gain_i[GAIN_FRAC-1:0]});
        shifted = mant <<< gain_i[GAIN_W-1 -: GAIN_EXP_W];
        // power-of-two shifter only; the fixed scaler is folded into the fraction point [R2] [R1]
        gain_d = shifted <<< shift_exp_i;
        comb_v[0] = '0;
        for (int k = 0; k < ORDER; k++) begin
            integ_d[k] = integ_q[k];
            dump_d[k] = dump_q[k];
            comb_v[k+1] = '0;
        end
        // each integrator is one clock of delay, gated by the sample enable [R8] [R9] [R10]
        if (samp_en_i) begin
            integ_d[0] = integ_q[0] + gain_q;
            integ_d[1] = integ_q[1] + integ_q[0];
            integ_d[2] = integ_q[2] + integ_q[1];
        end
        if (filt_i == FILT_DUMP) begin
            integ_d[1] = '0;
            integ_d[2] = '0;
            comb_v[ORDER] = integ_q[0] - dump_q[0];
        end else begin
            comb_v[1] = integ_q[2] - dump_q[0];
            comb_v[2] = comb_v[1] - dump_q[1];
            comb_v[3] = comb_v[2] - dump_q[2];
        end
        // dump side stores previous values once per output sample [R6]
        if (out_en_i) begin
            dump_d[0] = (filt_i == FILT_DUMP) ? integ_q[0] : integ_q[2];
            dump_d[1] = comb_v[1];
            dump_d[2] = comb_v[2];
        end
        comb_d = comb_q;
        if (filt_i == FILT_BYPASS) begin
            comb_d = gain_q;
        end else if (out_en_i) begin
            comb_d = comb_v[ORDER];
        end
        // round then saturate into the 11-bit window, never wrap [R12]
        pick = comb_q >>> (CIC_FRAC_SHIFT - SCALER_SHIFT + MIX_W);
        rnd = (pick + ACC_W'(1)) >>> 1;
        if (rnd > ACC_W'((1 <<< (CIC_W-1)) - 1)) begin
            sat_d = {1'b0, {(CIC_W-1){1'b1}}};
        end else if (rnd < -ACC_W'(1 <<< (CIC_W-1))) begin
            sat_d = {1'b1, {(CIC_W-1){1'b0}}};
        end else begin
            sat_d = CIC_W'(rnd);
        end
        // prev takes the old result on the edge where sat takes the new one,
        // so outside bypass the compensated output moves only once per output sample
        tap_en_d = out_en_i;
        prev_d = tap_en_q ? sat_q : prev_q;
        // two-tap sharpening stands in for the compensation shapes [R5]
        case (comp_i)
            COMP_SINC1: comp_acc = ((CIC_W+COMP_FRAC+3)'(sat_q) <<< COMP_FRAC)
                + ((CIC_W+COMP_FRAC+3)'(sat_q - prev_q) <<< (COMP_FRAC - 3));
            COMP_SINC3: comp_acc = ((CIC_W+COMP_FRAC+3)'(sat_q) <<< COMP_FRAC)
                + ((CIC_W+COMP_FRAC+3)'(sat_q - prev_q) <<< (COMP_FRAC - 2));
            default: comp_acc = (CIC_W+COMP_FRAC+3)'(sat_q) <<< COMP_FRAC;
        endcase
        // round and limit to 10 bits [R13]
        comp_rnd = (CIC_W+COMP_FRAC+3)'((comp_acc + (1 <<< COMP_FRAC)) >>> (COMP_FRAC + 1));
        if (comp_rnd > (CIC_W+COMP_FRAC+3)'((1 <<< (OUT_W-1)) - 1)) begin
            out_d = {1'b0, {(OUT_W-1){1'b1}}};
        end else if (comp_rnd < -(CIC_W+COMP_FRAC+3)'(1 <<< (OUT_W-1))) begin
            out_d = {1'b1, {(OUT_W-1){1'b0}}};
        end else begin
            out_d = OUT_W'(comp_rnd);
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mix_q <= '0;
            gain_q <= '0;
            comb_q <= '0;
            sat_q <= '0;
            prev_q <= '0;
            tap_en_q <= 1'b0;
            out_q <= '0;
            for (int k = 0; k < ORDER; k++) begin
                integ_q[k] <= '0; // [R16]
                dump_q[k] <= '0; // [R16]
            end
        end else begin
            mix_q <= mix_d;
            gain_q <= gain_d;
            comb_q <= comb_d;
            sat_q <= sat_d;
            prev_q <= prev_d;
            tap_en_q <= tap_en_d;
            out_q <= out_d;
            for (int k = 0; k < ORDER; k++) begin
                integ_q[k] <= integ_d[k];
                dump_q[k] <= dump_d[k];
            end
        end
    end

    assign out_o = out_q;
endmodule
`default_nettype wire

// *** core/decim_filter.sv ***
// Purpose: two matched legs with input gating, decimation divider and gain loop
// Assumes: converter data and mixer sinusoid arrive synchronous to clk_i
// Notes: gain loop drives both legs from the in-phase magnitude
`timescale 1ns/1ps
`default_nettype none
module decim_filter (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire decim_pkg::filt_cfg_t cfg_i,
    input wire logic input_sample_enable_i,
    input wire logic signed [decim_pkg::IN_W-1:0] data_i_i,
    input wire logic signed [decim_pkg::IN_W-1:0] data_q_i,
    input wire logic signed [decim_pkg::IN_W-1:0] lo_cos_i,
    input wire logic signed [decim_pkg::IN_W-1:0] lo_sin_i,
    output decim_pkg::iq_sample_t sample_o,
    output logic [decim_pkg::GAIN_W-1:0] adaptive_loop_gain_o
);
    import decim_pkg::*;

    localparam int PROD_W = MIX_W + IN_W;

    logic samp_en;
    logic [DIV_W-1:0] div_q, div_d;
    logic out_en_q, out_en_d;
    logic [VALID_LAG-1:0] out_en_dly_q, out_en_dly_d;
    logic [GAIN_W-1:0] gain_q, gain_d;
    logic [GAIN_W-2:0] code, code_nx, code_max, code_min;
    logic [GAIN_W:0] code_up;
    iq_sample_t smp_q, smp_d;
    logic signed [PROD_W-1:0] prod [2];
    logic signed [OUT_W-1:0] leg_out [2];
    logic [OUT_W-1:0] mag;

    ////////////////////////////////////////////////////////////////
    // one sample per asserted enable in gated mode, every clock otherwise [R11] [R9] [R10]
    assign samp_en = cfg_i.gated ? input_sample_enable_i : 1'b1;

    assign prod[0] = PROD_W'(data_i_i * lo_cos_i);
    assign prod[1] = PROD_W'(data_q_i * lo_sin_i);

    // identical legs, same stages, latency and enables [R4] [R1]
    for (genvar g = 0; g < 2; g++) begin : g_leg
        decim_leg u_leg (
            .clk_i(clk_i),
            .srst_i(srst_i),
            .samp_en_i(samp_en),
            .out_en_i(out_en_q),
            .filt_i(cfg_i.filt),
            .comp_i(cfg_i.comp),
            .shift_exp_i(cfg_i.shift_exp),
            .gain_i(gain_q),
            .prod_i(prod[g]),
            .out_o(leg_out[g])
        );
    end

    ////////////////////////////////////////////////////////////////
    always_comb begin
        // divider counts input samples; terminal count gives a one-clock pulse [R15]
        div_d = div_q;
        out_en_d = 1'b0;
        if (samp_en) begin
            if (div_q == DIV_ONE) begin
                div_d = cfg_i.divisor_m1;
                out_en_d = 1'b1;
            end else begin
                div_d = div_q - DIV_W'(1);
            end
        end
        // valid rides along with the leg pipeline so it flags the fresh i and q
        out_en_dly_d = {out_en_dly_q[VALID_LAG-2:0], out_en_q};
        mag = leg_out[0][OUT_W-1] ? OUT_W'(-leg_out[0]) : OUT_W'(leg_out[0]);
        // step the packed 7-bit code: stepping the raw byte would let each carry
        // out of the fraction land in the unused bit and drop the mantissa to unity
        code = {gain_q[GAIN_W-1 -: GAIN_EXP_W], gain_q[GAIN_FRAC-1:0]};
        code_max = {GAIN_MAX[GAIN_W-1 -: GAIN_EXP_W], GAIN_MAX[GAIN_FRAC-1:0]};
        code_min = {GAIN_MIN[GAIN_W-1 -: GAIN_EXP_W], GAIN_MIN[GAIN_FRAC-1:0]};
        code_up = {2'b00, code} + {1'b0, cfg_i.loop_gain_step};
        code_nx = code;
        // loop accumulator moves once per output sample, clamped to its span [R7] [R14]
        if (out_en_dly_q[VALID_LAG-1]) begin
            if (mag < cfg_i.level_target) begin
                code_nx = (code_up > {2'b00, code_max}) ? code_max : (GAIN_W-1)'(code_up);
            end else if (mag > cfg_i.level_target) begin
                code_nx = ({2'b00, code} < {2'b00, code_min} + {1'b0, cfg_i.loop_gain_step})
                    ? code_min : (GAIN_W-1)'({1'b0, code} - cfg_i.loop_gain_step);
            end
        end
        gain_d = {code_nx[GAIN_W-2 -: GAIN_EXP_W], 1'b0, code_nx[GAIN_FRAC-1:0]};
        smp_d.valid = out_en_dly_q[VALID_LAG-1];
        smp_d.i = leg_out[0];
        smp_d.q = leg_out[1];
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            div_q <= DIV_ONE;
            out_en_q <= 1'b0;
            out_en_dly_q <= '0;
            gain_q <= GAIN_MIN; // [R16]
            smp_q <= '0;
        end else begin
            div_q <= div_d;
            out_en_q <= out_en_d;
            out_en_dly_q <= out_en_dly_d;
            gain_q <= gain_d;
            smp_q <= smp_d;
        end
    end

    assign sample_o = smp_q;
    assign adaptive_loop_gain_o = gain_q;
endmodule
`default_nettype wire

// *** verif/decim_filter_chk.sv ***
// Purpose: port checks for the decimating filter
// Assumes: cfg_i held static between resets
// Notes: output spacing is judged in interpolated mode only
`timescale 1ns/1ps
`default_nettype none
module decim_filter_chk (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire decim_pkg::filt_cfg_t cfg_i,
    input wire logic input_sample_enable_i,
    input wire decim_pkg::iq_sample_t sample_o,
    input wire logic [decim_pkg::GAIN_W-1:0] adaptive_loop_gain_o
);
    import decim_pkg::*;
    logic adm;
    logic seen_q, seen_d, fed_q, fed_d;
    logic [DIV_W-1:0] gap_q, gap_d;
    assign adm = !cfg_i.gated || input_sample_enable_i;
    always_comb begin
        seen_d = seen_q | sample_o.valid;
        fed_d = fed_q | adm;
        gap_d = sample_o.valid ? '0 : gap_q + 12'h001;
    end
    always_ff @(posedge clk_i) begin
        seen_q <= srst_i ? 1'b0 : seen_d;
        fed_q <= srst_i ? 1'b0 : fed_d;
        gap_q <= srst_i ? '0 : gap_d;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    ////////////////////////////////////////////////////////////////////////
    a_reset_zero: assert property ($fell(srst_i) |->
        sample_o == '0 && adaptive_loop_gain_o == '0)
        else $error("outputs not cleared by reset");
    a_valid_admitted: assert property (sample_o.valid |-> $past(adm, 5))
        else $error("output without admitted sample");
    a_first_lag: assert property (adm && cfg_i.gated && !fed_q |-> ##5 sample_o.valid)
        else $error("first output not five clocks after first sample");
    a_single_pulse: assert property (sample_o.valid && cfg_i.divisor_m1 != 12'h000 |=>
        !sample_o.valid)
        else $error("valid longer than one clock");
    a_out_period: assert property (sample_o.valid && seen_q && !cfg_i.gated |->
        gap_q == cfg_i.divisor_m1)
        else $error("output spacing wrong");
    a_gain_steady: assert property (!$stable(adaptive_loop_gain_o) |-> sample_o.valid)
        else $error("gain moved between outputs");
    a_iq_hold: assert property (cfg_i.filt != FILT_BYPASS &&
        (!$stable(sample_o.i) || !$stable(sample_o.q)) |-> sample_o.valid)
        else $error("output data moved between outputs");
    a_gain_code: assert property (adaptive_loop_gain_o[4] == 1'b0)
        else $error("unused gain bit set");
endmodule
bind decim_filter decim_filter_chk chk (.clk_i(clk_i), .srst_i(srst_i), .cfg_i(cfg_i),
    .input_sample_enable_i(input_sample_enable_i), .sample_o(sample_o),
    .adaptive_loop_gain_o(adaptive_loop_gain_o));
`default_nettype wire

// *** verif/adc_model.sv ***
// Purpose: converter data and constant mixer reference source
// Assumes: drives on the falling edge
// Notes: between gated samples the data is inverted so stale values never look valid
`timescale 1ns/1ps
`default_nettype none
module adc_model (
    input wire logic clk_i,
    input wire logic gated_i,
    input wire logic run_i,
    input wire logic [3:0] every_i,
    input wire logic signed [9:0] amp_i,
    output logic input_sample_enable_o,
    output logic signed [decim_pkg::IN_W-1:0] data_i_o,
    output logic signed [decim_pkg::IN_W-1:0] data_q_o,
    output logic signed [decim_pkg::IN_W-1:0] lo_cos_o,
    output logic signed [decim_pkg::IN_W-1:0] lo_sin_o
);
    logic [3:0] cnt = 4'h0;
    logic en;
    assign en = run_i && cnt == every_i;
    initial begin
        input_sample_enable_o = 1'b0;
        lo_cos_o = 10'h1FF;
        lo_sin_o = 10'h1FF;
    end
    always @(negedge clk_i) begin
        cnt <= en ? 4'h0 : cnt + 4'h1;
        input_sample_enable_o <= gated_i && en;
        data_i_o <= (!gated_i || en) ? amp_i : ~amp_i;
        data_q_o <= (!gated_i || en) ? amp_i : ~amp_i;
    end
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// Purpose: self-checking bench for the decimating filter
// Assumes: adc_model supplies the data stream
// Notes: every scenario restarts from reset with a static configuration
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import decim_pkg::*;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    filt_cfg_t cfg_i = '0;
    logic run = 1'b1;
    logic [3:0] every = 4'h0;
    logic [SHIFT_W-1:0] shift = 6'h00;
    logic signed [9:0] amp = 10'h000;
    logic en;
    logic signed [IN_W-1:0] di, dq, lc, ls;
    iq_sample_t sample_o;
    logic [GAIN_W-1:0] gain;
    int fails = 0;
    int comparisons = 0;
    int k;
    initial forever #25 clk_i = ~clk_i;
    adc_model src (.clk_i(clk_i), .gated_i(cfg_i.gated), .run_i(run), .every_i(every),
        .amp_i(amp), .input_sample_enable_o(en), .data_i_o(di), .data_q_o(dq),
        .lo_cos_o(lc), .lo_sin_o(ls));
    decim_filter DUT (.clk_i(clk_i), .srst_i(srst_i), .cfg_i(cfg_i), .input_sample_enable_i(en),
        .data_i_i(di), .data_q_i(dq), .lo_cos_i(lc), .lo_sin_i(ls), .sample_o(sample_o),
        .adaptive_loop_gain_o(gain));
    ////////////////////////////////////////////////////////////////////////
    task conclude();
        if (fails == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task miss(input string m);
        fails++;
        $display("mismatch at %0t: %s", $time, m);
    endtask
    // reset is held 8 clocks so the pipeline is fully cleared each time
    task start(input filt_mode_t f, input comp_mode_t c, input logic g, input logic [11:0] d);
        @(negedge clk_i);
        srst_i = 1'b1;
        cfg_i = '{filt: f, comp: c, gated: g, shift_exp: shift, divisor_m1: d,
            loop_gain_step: 8'h01, level_target: 10'h1FF};
        repeat (8) @(negedge clk_i);
        srst_i = 1'b0;
    endtask
    task count_valid(input int n);
        k = 0;
        repeat (n) begin
            @(negedge clk_i);
            if (sample_o.valid === 1'b1) k++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task s_interp();
        start(FILT_CIC3, COMP_NONE, 1'b0, 12'h003);
        count_valid(20);
        count_valid(40);
        if (k !== 10) miss("interpolated output count"); else comparisons++;
    endtask
    task s_gated();
        every = 4'h2;
        start(FILT_CIC3, COMP_SINC1, 1'b1, 12'h001);
        count_valid(21);
        count_valid(60);
        if (k !== 10) miss("gated output count"); else comparisons++;
        run = 1'b0;
        // samples already admitted may still emerge; let the pipeline drain first
        count_valid(8);
        count_valid(30);
        if (k !== 0) miss("output while stalled"); else comparisons++;
        run = 1'b1;
        every = 4'h0;
    endtask
    task s_modes();
        for (int a = 0; a < 2; a++) begin
            for (int f = 0; f < 3; f++) begin
                for (int c = 0; c < 3; c++) begin
                    amp = a ? 10'h0C8 : 10'h000;
                    start(filt_mode_t'(f), comp_mode_t'(c), 1'b0, 12'h003);
                    count_valid(30);
                    if (sample_o.i !== sample_o.q) miss("legs differ"); else comparisons++;
                    if (a == 0 && sample_o.i !== 10'h000) miss("zero not kept"); else comparisons++;
                end
            end
        end
    endtask
    task s_gain();
        amp = 10'h008;
        start(FILT_DUMP, COMP_NONE, 1'b0, 12'h003);
        count_valid(200);
        if (gain === 8'h00) miss("gain loop idle"); else comparisons++;
        count_valid(400);
        if (gain !== 8'hEF) miss("gain not held at its ceiling"); else comparisons++;
    endtask
    // a large exponent drives the comb past its window; outputs must pin, not wrap
    task s_sat();
        shift = 6'h10;
        for (int a = 0; a < 2; a++) begin
            amp = a ? 10'h338 : 10'h0C8;
            start(FILT_CIC3, COMP_SINC1, 1'b0, 12'h003);
            count_valid(30);
            if (sample_o.i !== (a ? 10'h200 : 10'h1FF)) miss("output not limited"); else comparisons++;
            if (sample_o.q !== sample_o.i) miss("legs differ when limited"); else comparisons++;
        end
        shift = 6'h00;
    endtask
    initial begin
        s_interp();
        s_gated();
        s_modes();
        s_gain();
        s_sat();
        conclude();
    end
    initial begin
        #1000000;
        fails++;
        conclude();
    end
endmodule
`default_nettype wire
